// ### shared/adcr_params.svh
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define ADCR_OFS_CTRL      8'h00
`define ADCR_OFS_CFG       8'h04
`define ADCR_OFS_RES       8'h08
`define ADCR_OFS_ANSA      8'h0c
`define ADCR_OFS_ANSB      8'h10
`define ADCR_OFS_ANSE      8'h14
`define ADCR_OFS_STAT      8'h18
`define ADCR_OFS_MASK      8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCR_CTRL_ON       0
`define ADCR_CTRL_GO       1
`define ADCR_CHS_LSB       2
`define ADCR_CHS_MSB       5
`define ADCR_CONV_CLOCK_SELECT_LSB      4
`define ADCR_CONV_CLOCK_SELECT_MSB      6
`define ADCR_REF_LSB       0
`define ADCR_REF_MSB       1
`define ADCR_IRQ_DONE      0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ADCR_CHS_RST       4'h0
`define ADCR_CONV_CLOCK_SELECT_RST      3'h0
`define ADCR_REF_RST       2'h0
`define ADCR_ANSA_RST      6'h3f
`define ADCR_ANSB_RST      6'h3f
`define ADCR_ANSE_RST      3'h7

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define ADCR_CS_D2         3'h0
`define ADCR_CS_D8         3'h1
`define ADCR_CS_D32        3'h2
`define ADCR_CS_RC_A       3'h3
`define ADCR_CS_D4         3'h4
`define ADCR_CS_D16        3'h5
`define ADCR_CS_D64        3'h6
`define ADCR_CS_RC_B       3'h7
`define ADCR_REF_EXT       2'h2
`define ADCR_REF_FVR       2'h3
`define ADCR_CH_FVR        4'hf

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define ADCR_TERM_D2       6'h01
`define ADCR_TERM_D4       6'h03
`define ADCR_TERM_D8       6'h07
`define ADCR_TERM_D16      6'h0f
`define ADCR_TERM_D32      6'h1f
`define ADCR_TERM_D64      6'h3f
`define ADCR_CONV_LAST     4'ha

`endif

// ### shared/adcr_pkg.sv
package adcr_pkg;

   typedef enum logic {
      st_idle,
      st_convert
   } adcr_state_t;

   typedef logic [7:0] adcr_byte_t;

endpackage : adcr_pkg

// ### core/adcr_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcr_params.svh"

module adcr_clkdiv (
   input  wire logic       clk,      // System clock.
   input  wire logic       rst_n,    // Asynchronous reset, active low.
   input  wire logic       run,      // Converter enabled.
   input  wire logic [2:0] clk_sel,  // Conversion clock select code.
   input  wire logic       rc_tick,  // Dedicated RC oscillator tick.
   output logic            tick_q    // Conversion clock enable pulse.
);

   logic [5:0] cnt_q;
   logic [5:0] term;
   logic       rc_sel;

   always_comb begin
      rc_sel = 1'b0;
      unique case (clk_sel)
         `ADCR_CS_D2:   term = `ADCR_TERM_D2;
         `ADCR_CS_D8:   term = `ADCR_TERM_D8;
         `ADCR_CS_D32:  term = `ADCR_TERM_D32;
         `ADCR_CS_D4:   term = `ADCR_TERM_D4;
         `ADCR_CS_D16:  term = `ADCR_TERM_D16;
         `ADCR_CS_D64:  term = `ADCR_TERM_D64;
         `ADCR_CS_RC_A: begin
            term   = `ADCR_TERM_D2;
            rc_sel = 1'b1;
         end
         `ADCR_CS_RC_B: begin
            term   = `ADCR_TERM_D2;
            rc_sel = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= 6'h00;
         tick_q <= 1'b0;
      end else if (!run || rc_sel) begin
         cnt_q  <= 6'h00;
         tick_q <= run & rc_tick;
      end else if (cnt_q == term) begin
         cnt_q  <= 6'h00;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 6'h01;
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_rc_route;
      @(posedge clk) disable iff (!rst_n)
      (run && (clk_sel == `ADCR_CS_RC_A || clk_sel == `ADCR_CS_RC_B))
         |=> (tick_q == $past(rc_tick));
   endproperty
   a_rc_route: assert property (p_rc_route) else $error("RC clock not routed.");

   property p_div2;
      @(posedge clk) disable iff (!rst_n)
      (tick_q && run && clk_sel == `ADCR_CS_D2) ##1 (run && clk_sel == `ADCR_CS_D2)
         |-> !tick_q ##1 tick_q;
   endproperty
   a_div2: assert property (p_div2) else $error("Divide by 2 period wrong.");

   property p_div4;
      @(posedge clk) disable iff (!rst_n)
      (tick_q && run && clk_sel == `ADCR_CS_D4) ##1 (run && clk_sel == `ADCR_CS_D4)[*4]
         |-> tick_q && $past(!tick_q) && $past(!tick_q, 2) && $past(!tick_q, 3);
   endproperty
   a_div4: assert property (p_div4) else $error("Divide by 4 period wrong.");

endmodule : adcr_clkdiv
`default_nettype wire

// ### core/adcr_regs.sv
// Summary of operation
// - Clock select codes divide system clock
// - Codes 011 and 111 use RC clock
// - Reference code picks supply, external, fixed
// - Config bits 7,3,2 read zero
// - Result byte readable and software writable
// - Result kept across non power resets
// - Go starts conversion, cleared when done
// - Channel code 1111 selects fixed reference
// - Converter off disables all conversion activity
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "adcr_params.svh"

module adcr_regs (
   input  wire logic        hclk,          // System clock.
   input  wire logic        hresetn,       // Power-on reset, active low.
   input  wire logic        other_reset,   // Other device resets, synchronous.
   input  wire logic        hsel,          // Slave select.
   input  wire logic [31:0] haddr,         // Byte address.
   input  wire logic [1:0]  htrans,        // Transfer type.
   input  wire logic        hwrite,        // Write when high.
   input  wire logic [2:0]  hsize,         // Transfer size.
   input  wire logic [31:0] hwdata,        // Write data.
   input  wire logic        hready,        // Bus ready.
   output logic      [31:0] hrdata,        // Read data.
   output logic             hreadyout,     // Slave ready.
   output logic             hresp,         // Response, always OKAY.
   input  wire logic        rc_tick,       // Dedicated RC oscillator tick.
   input  wire logic [7:0]  sar_result,    // Converter core result.
   output logic             adc_enable,    // Converter powered.
   output logic             conv_tick,     // Conversion clock enable.
   output logic             conv_busy,     // Conversion running.
   output logic             conv_done,     // Conversion end pulse.
   output logic      [3:0]  channel_sel,   // Input channel code.
   output logic             fvr_input_sel, // Fixed reference is the input.
   output logic             ref_vdd,       // Reference from supply.
   output logic             ref_ext,       // Reference from external pin.
   output logic             ref_fvr,       // Reference from fixed reference.
   output logic      [7:0]  result_byte,   // Result register.
   output logic      [5:0]  port_a_ana,    // Port A analog select.
   output logic      [5:0]  port_b_ana,    // Port B analog select.
   output logic      [2:0]  port_e_ana,    // Port E analog select.
   output logic             irq            // Interrupt, active high level.
);

   // ----------------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------------
   logic                addr_ok;
   logic                dp_wr_q;
   logic                dp_rd_q;
   logic [7:0]          dp_addr_q;
   logic [31:0]         hrdata_q;
   logic                hreadyout_q;
   logic                hresp_q;
   adcr_pkg::adcr_byte_t rd_byte;

   assign addr_ok = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_q   <= 1'b0;
         dp_rd_q   <= 1'b0;
         dp_addr_q <= 8'h00;
      end else begin
         dp_wr_q   <= addr_ok & hwrite;
         dp_rd_q   <= addr_ok & ~hwrite;
         dp_addr_q <= haddr[7:0];
      end
   end

   // Reads take one wait state so that a write just committed is seen.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h0000_0000;
         hresp_q     <= 1'b0;
      end else begin
         hreadyout_q <= ~(addr_ok & ~hwrite);
         hresp_q     <= 1'b0;
         if (dp_rd_q) begin
            hrdata_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;

   logic wr_ctrl;
   logic wr_cfg;
   logic wr_res;
   logic wr_ansa;
   logic wr_ansb;
   logic wr_anse;
   logic wr_stat;
   logic wr_mask;

   assign wr_ctrl = dp_wr_q && (dp_addr_q == `ADCR_OFS_CTRL);
   assign wr_cfg  = dp_wr_q && (dp_addr_q == `ADCR_OFS_CFG);
   assign wr_res  = dp_wr_q && (dp_addr_q == `ADCR_OFS_RES);
   assign wr_ansa = dp_wr_q && (dp_addr_q == `ADCR_OFS_ANSA);
   assign wr_ansb = dp_wr_q && (dp_addr_q == `ADCR_OFS_ANSB);
   assign wr_anse = dp_wr_q && (dp_addr_q == `ADCR_OFS_ANSE);
   assign wr_stat = dp_wr_q && (dp_addr_q == `ADCR_OFS_STAT);
   assign wr_mask = dp_wr_q && (dp_addr_q == `ADCR_OFS_MASK);

   // ----------------------------------------------------------------------------
   // Control and configuration registers
   // ----------------------------------------------------------------------------
   logic       converter_on_bit_q;
   logic [3:0] chs_q;
   logic       fvr_in_q;
   logic [2:0] conv_clock_select_q;
   logic [1:0] ref_q;
   logic       ref_vdd_q;
   logic       ref_ext_q;
   logic       ref_fvr_q;
   logic [5:0] ansa_q;
   logic [5:0] ansb_q;
   logic [2:0] anse_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         converter_on_bit_q   <= 1'b0;
         chs_q    <= `ADCR_CHS_RST;
         fvr_in_q <= 1'b0;
      end else if (other_reset) begin
         converter_on_bit_q   <= 1'b0;
         chs_q    <= `ADCR_CHS_RST;
         fvr_in_q <= 1'b0;
      end else if (wr_ctrl) begin
         converter_on_bit_q   <= hwdata[`ADCR_CTRL_ON];
         chs_q    <= hwdata[`ADCR_CHS_MSB:`ADCR_CHS_LSB];
         fvr_in_q <= (hwdata[`ADCR_CHS_MSB:`ADCR_CHS_LSB] == `ADCR_CH_FVR);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_clock_select_q    <= `ADCR_CONV_CLOCK_SELECT_RST;
         ref_q     <= `ADCR_REF_RST;
         ref_vdd_q <= 1'b1;
         ref_ext_q <= 1'b0;
         ref_fvr_q <= 1'b0;
      end else if (other_reset) begin
         conv_clock_select_q    <= `ADCR_CONV_CLOCK_SELECT_RST;
         ref_q     <= `ADCR_REF_RST;
         ref_vdd_q <= 1'b1;
         ref_ext_q <= 1'b0;
         ref_fvr_q <= 1'b0;
      end else if (wr_cfg) begin
         conv_clock_select_q    <= hwdata[`ADCR_CONV_CLOCK_SELECT_MSB:`ADCR_CONV_CLOCK_SELECT_LSB];
         ref_q     <= hwdata[`ADCR_REF_MSB:`ADCR_REF_LSB];
         ref_vdd_q <= ~hwdata[`ADCR_REF_MSB];
         ref_ext_q <= (hwdata[`ADCR_REF_MSB:`ADCR_REF_LSB] == `ADCR_REF_EXT);
         ref_fvr_q <= (hwdata[`ADCR_REF_MSB:`ADCR_REF_LSB] == `ADCR_REF_FVR);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ansa_q <= `ADCR_ANSA_RST;
         ansb_q <= `ADCR_ANSB_RST;
         anse_q <= `ADCR_ANSE_RST;
      end else if (other_reset) begin
         ansa_q <= `ADCR_ANSA_RST;
         ansb_q <= `ADCR_ANSB_RST;
         anse_q <= `ADCR_ANSE_RST;
      end else begin
         if (wr_ansa) begin
            ansa_q <= hwdata[5:0];
         end
         if (wr_ansb) begin
            ansb_q <= hwdata[5:0];
         end
         if (wr_anse) begin
            anse_q <= hwdata[2:0];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------------------
   adcr_pkg::adcr_state_t state_q;
   logic                  go_q;
   logic [3:0]            cnt_q;
   logic                  done_pulse_q;
   logic                  tick;
   logic                  start;
   logic                  fin;
   logic [7:0]            result_q;

   adcr_clkdiv u_clkdiv (
      .clk     (hclk),
      .rst_n   (hresetn),
      .run     (converter_on_bit_q),
      .clk_sel (conv_clock_select_q),
      .rc_tick (rc_tick),
      .tick_q  (tick)
   );

   assign start = wr_ctrl && hwdata[`ADCR_CTRL_GO] && hwdata[`ADCR_CTRL_ON]
                  && (state_q == adcr_pkg::st_idle) && !other_reset;
   assign fin   = (state_q == adcr_pkg::st_convert) && converter_on_bit_q && !other_reset
                  && tick && (cnt_q == `ADCR_CONV_LAST);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q      <= adcr_pkg::st_idle;
         go_q         <= 1'b0;
         cnt_q        <= 4'h0;
         done_pulse_q <= 1'b0;
      end else if (other_reset || (state_q == adcr_pkg::st_convert && !converter_on_bit_q)) begin
         state_q      <= adcr_pkg::st_idle;
         go_q         <= 1'b0;
         cnt_q        <= 4'h0;
         done_pulse_q <= 1'b0;
      end else begin
         done_pulse_q <= fin;
         unique case (state_q)
            adcr_pkg::st_idle: begin
               if (start) begin
                  state_q <= adcr_pkg::st_convert;
                  go_q    <= 1'b1;
                  cnt_q   <= 4'h0;
               end
            end
            adcr_pkg::st_convert: begin
               if (fin) begin
                  state_q <= adcr_pkg::st_idle;
                  go_q    <= 1'b0;
               end else if (tick) begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk) begin
      if (fin) begin
         result_q <= sar_result;
      end else if (wr_res) begin
         result_q <= hwdata[7:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------------------
   logic done_st_q;
   logic done_st_d;
   logic mask_q;
   logic mask_d;
   logic irq_q;

   always_comb begin
      done_st_d = done_st_q;
      if (wr_stat && hwdata[`ADCR_IRQ_DONE]) begin
         done_st_d = 1'b0;
      end
      if (fin) begin
         done_st_d = 1'b1;
      end
      mask_d = wr_mask ? hwdata[`ADCR_IRQ_DONE] : mask_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_st_q <= 1'b0;
         mask_q    <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         done_st_q <= done_st_d;
         mask_q    <= mask_d;
         irq_q     <= done_st_d & mask_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------------
   // unimplemented bits zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (dp_addr_q)
         `ADCR_OFS_CTRL: rd_byte = {2'h0, chs_q, go_q, converter_on_bit_q};
         `ADCR_OFS_CFG:  rd_byte = {1'b0, conv_clock_select_q, 2'h0, ref_q};
         `ADCR_OFS_RES:  rd_byte = result_q;
         `ADCR_OFS_ANSA: rd_byte = {2'h0, ansa_q};
         `ADCR_OFS_ANSB: rd_byte = {2'h0, ansb_q};
         `ADCR_OFS_ANSE: rd_byte = {5'h00, anse_q};
         `ADCR_OFS_STAT: rd_byte = {7'h00, done_st_q};
         `ADCR_OFS_MASK: rd_byte = {7'h00, mask_q};
         default:        rd_byte = 8'h00;
      endcase
   end

   assign adc_enable    = converter_on_bit_q;
   assign conv_tick     = tick;
   assign conv_busy     = go_q;
   assign conv_done     = done_pulse_q;
   assign channel_sel   = chs_q;
   assign fvr_input_sel = fvr_in_q;
   assign ref_vdd       = ref_vdd_q;
   assign ref_ext       = ref_ext_q;
   assign ref_fvr       = ref_fvr_q;
   assign result_byte   = result_q;
   assign port_a_ana    = ansa_q;
   assign port_b_ana    = ansb_q;
   assign port_e_ana    = anse_q;
   assign irq           = irq_q;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_ref_ext;
      @(posedge hclk) disable iff (!hresetn)
      (wr_cfg && !other_reset && hwdata[1:0] == `ADCR_REF_EXT)
         |=> ref_ext && !ref_vdd && !ref_fvr;
   endproperty
   a_ref_ext: assert property (p_ref_ext) else $error("External reference not chosen.");

   property p_cfg_zero;
      @(posedge hclk) disable iff (!hresetn)
      (dp_rd_q && dp_addr_q == `ADCR_OFS_CFG) |=> (hrdata[7] == 1'b0) && (hrdata[3:2] == 2'h0);
   endproperty
   a_cfg_zero: assert property (p_cfg_zero) else $error("Unused config bits not zero.");

   property p_res_write;
      @(posedge hclk) disable iff (!hresetn)
      (wr_res && !fin) |=> (result_byte == $past(hwdata[7:0]));
   endproperty
   a_res_write: assert property (p_res_write) else $error("Result write lost.");

   property p_res_keep;
      @(posedge hclk) disable iff (!hresetn)
      (other_reset && !fin && !wr_res) |=> $stable(result_byte);
   endproperty
   a_res_keep: assert property (p_res_keep) else $error("Result changed on reset.");

   property p_go_start;
      @(posedge hclk) disable iff (!hresetn)
      start |=> conv_busy ##1 (conv_busy || $past(fin));
   endproperty
   a_go_start: assert property (p_go_start) else $error("Go flag not set.");

   property p_chan_fvr;
      @(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && !other_reset && hwdata[5:2] == `ADCR_CH_FVR)
         |=> fvr_input_sel && channel_sel == `ADCR_CH_FVR;
   endproperty
   a_chan_fvr: assert property (p_chan_fvr) else $error("Fixed reference input not chosen.");

   property p_off;
      @(posedge hclk) disable iff (!hresetn)
      (!converter_on_bit_q && !wr_ctrl) |=> !conv_busy && !conv_tick;
   endproperty
   a_off: assert property (p_off) else $error("Activity while converter off.");

   property p_finish;
      @(posedge hclk) disable iff (!hresetn)
      fin |=> !conv_busy && (result_byte == $past(sar_result)) && done_st_q ##1 irq == mask_q;
   endproperty
   a_finish: assert property (p_finish) else $error("Finish not aligned with load.");

   c_conv_done: cover property (@(posedge hclk) disable iff (!hresetn) start ##[1:800] fin);
   c_rc_conv: cover property (@(posedge hclk) disable iff (!hresetn)
      fin && conv_clock_select_q == `ADCR_CS_RC_B);
   c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq ##1 !irq);

endmodule : adcr_regs
`default_nettype wire

// ### tb/adcr_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcr_front_model #(
   parameter int RC_PER = 5           // RC oscillator period in hclk cycles.
) (
   input  wire logic       hclk,      // System clock.
   input  wire logic       hresetn,   // Reset, active low.
   input  wire logic       conv_busy, // Conversion running.
   input  wire logic [7:0] sample,    // Level of the selected input.
   output logic            rc_tick,   // RC oscillator tick.
   output logic      [7:0] sar_result // Converter core result.
);
   int cnt;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt        <= 0;
         rc_tick    <= 1'b0;
         sar_result <= 8'h00;
      end else begin
         cnt     <= (cnt == RC_PER - 1) ? 0 : cnt + 1;
         rc_tick <= (cnt == RC_PER - 1);
         sar_result <= conv_busy ? sample : ~sar_result;
      end
   end
endmodule : adcr_front_model
`default_nettype wire

// ### tb/adc_config_and_result_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_config_and_result_regs_tb;
   logic        hclk = 0, hresetn = 0, other_reset = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0]  htrans = 0;
   logic [7:0]  sar_result, result_byte, sample = 0;
   logic [3:0]  channel_sel, ch;
   logic [5:0]  port_a_ana, port_b_ana;
   logic [2:0]  port_e_ana;
   logic        hreadyout, hresp, rc_tick, adc_enable, conv_tick, conv_busy, conv_done;
   logic        fvr_input_sel, ref_vdd, ref_ext, ref_fvr, irq;
   logic [31:0] mreg [8] = '{0, 0, 'x, 32'h3f, 32'h3f, 32'h07, 0, 0};
   logic [31:0] wm [8] = '{32'h3d, 32'h73, 32'hff, 32'h3f, 32'h3f, 32'h07, 0, 32'h01};
   int          gaps [8] = '{2, 8, 32, 5, 4, 16, 64, 5};
   int          n_errors = 0, n_tests = 0, seed = 94, n;

   always #12.5 hclk = ~hclk;

   adcr_regs adcr_regs_inst (.hclk, .hresetn, .other_reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rc_tick,
      .sar_result, .adc_enable, .conv_tick, .conv_busy, .conv_done, .channel_sel,
      .fvr_input_sel, .ref_vdd, .ref_ext, .ref_fvr, .result_byte, .port_a_ana, .port_b_ana,
      .port_e_ana, .irq);

   adcr_front_model adcr_front_model_inst (.hclk, .hresetn, .conv_busy, .sample, .rc_tick,
      .sar_result);

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      if (a == 8'h18) mreg[6] &= ~d;
      else if (a < 8'h20) mreg[a[4:2]] = d & wm[a[4:2]];
   endtask : wr

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
      cmp(r, (a < 8'h20) ? mreg[a[4:2]] : 32'h0);
   endtask : rd

   task automatic gap(output int g);
      g = 0;
      @(posedge hclk iff conv_tick === 1'b1);
      do begin
         @(posedge hclk);
         g++;
      end while (conv_tick !== 1'b1);
   endtask : gap

   task end_of_test;
      if (n_errors == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   initial begin
      #(25 * 20000);
      n_errors++;
      end_of_test;
   end

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 9; i++) if (i != 2) rd(8'(4 * i));
      wr(8'h00, 32'h01);
      for (int c = 0; c < 8; c++) begin
         wr(8'h04, {24'h0, 1'b1, 3'(c), 2'b11, 2'(c)});
         rd(8'h04);
         cmp({ref_vdd, ref_ext, ref_fvr}, c[1] ? (c[0] ? 3'b001 : 3'b010) : 3'b100);
         gap(n);
         gap(n);
         cmp(n, gaps[c]);
      end
      wr(8'h00, 32'h02);
      repeat (2) @(posedge hclk);
      n = 0;
      repeat (100) @(posedge hclk) n += (conv_tick !== 1'b0);
      cmp({n[29:0], conv_busy, adc_enable}, 32'h0);
      rd(8'h00);
      wr(8'h04, 32'h10);
      wr(8'h1c, 32'h01);
      for (int k = 0; k < 2; k++) begin
         ch = k ? 4'hf : 4'($unsigned($random(seed)) % 14);
         wr(8'h00, {26'h0, ch, 2'b01});
         repeat (40) @(posedge hclk);
         cmp({channel_sel, fvr_input_sel}, {ch, ch == 4'hf});
         sample = 8'($random(seed));
         wr(8'h00, {26'h0, ch, 2'b11});
         n = 0;
         for (int t = 0; t < 3000; t++) begin
            @(posedge hclk);
            if (conv_tick === 1'b1 && conv_busy === 1'b1) n++;
            #1;
            if (conv_busy !== 1'b1) break;
         end
         cmp(n, 11);
         cmp(result_byte, sample);
         mreg[2] = sample;
         mreg[6] = 1;
         cmp({conv_done, irq}, 2'b11);
         @(posedge hclk);
         #1 cmp({conv_done, irq}, 2'b01);
         rd(8'h00);
         rd(8'h08);
         rd(8'h18);
         wr(8'h18, 32'h01);
         @(posedge hclk);
         #1 cmp(irq, 0);
      end
      wr(8'h08, $random(seed));
      wr(8'h0c, $random(seed));
      wr(8'h04, $random(seed));
      rd(8'h08);
      @(posedge hclk) other_reset <= 1'b1;
      @(posedge hclk) other_reset <= 1'b0;
      mreg[0:1] = '{0, 0};
      mreg[3:5] = '{32'h3f, 32'h3f, 32'h07};
      for (int i = 0; i < 8; i++) rd(8'(4 * i));
      end_of_test;
   end
endmodule : adc_config_and_result_regs_tb
`default_nettype wire
